// ==== logic/sys_config_pkg.sv ====
package sys_config_pkg;
  // auxiliary control register layout
  localparam logic [7:0] aux_ctrl_addr = 8'hA2;
  localparam int aux_software_reset_trigger_bit = 3;
  localparam int aux_zero_bit = 2;
  localparam int aux_dps_bit = 0;
  localparam logic [7:0] aux_write_mask = 8'hFB;
  localparam logic [7:0] aux_reset_value = 8'h00;
  // pointer byte register addresses
  localparam logic [7:0] ptr_low_addr = 8'h82;
  localparam logic [7:0] ptr_high_addr = 8'h83;
  localparam logic [15:0] ptr_reset_value = 16'h0000;
  localparam logic [15:0] restart_address = 16'h0000;
  // code and data space map
  localparam logic [15:0] sig_addr_0 = 16'hFC30;
  localparam logic [15:0] sig_addr_1 = 16'hFC31;
  localparam logic [15:0] sig_addr_2 = 16'hFC60;
  localparam logic [15:0] cust_base = 16'hFCE0;
  localparam logic [15:0] cust_last = 16'hFCFF;
  localparam logic [15:0] cfg1_addr = 16'hFD00;
  localparam logic [15:0] cfg2_addr = 16'hFD01;
  localparam int cust_depth = 32;
  localparam int cust_aw = 5;
  // configuration byte one fields
  localparam int cfg_watchdog_config_enable_bit = 7;
  localparam int cfg_rpd_bit = 6;
  localparam int cfg_port_reset_level_bit = 5;
  localparam int cfg_bov_bit = 4;
  localparam int cfg_clock_rate_select_bit = 3;
  localparam logic [7:0] cfg_unprog_value = 8'hFF;
  localparam int machine_cycle_clocks = 12;
  localparam int machine_cycle_fast = 6;
  // programmer link
  localparam int prog_frame_bits = 32;

  typedef enum logic [2:0] {
    osc_high_xtal = 3'b000,
    osc_med_xtal = 3'b001,
    osc_low_xtal = 3'b010,
    osc_int_rc = 3'b011,
    osc_reserved = 3'b100,
    osc_ext_clock = 3'b111
  } osc_mode_t;

  typedef enum logic [3:0] {
    cmd_nop = 4'h0,
    cmd_write_code = 4'h1,
    cmd_read_code = 4'h2,
    cmd_write_cfg = 4'h3,
    cmd_read_cfg = 4'h4,
    cmd_prog_sb1 = 4'h5,
    cmd_prog_sb2 = 4'h6
  } prog_cmd_t;

  typedef enum logic [1:0] {
    link_idle = 2'b00,
    link_shift_in = 2'b01,
    link_exec = 2'b10,
    link_shift_out = 2'b11
  } link_state_t;

  // core special function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // pointer instruction strobes
  typedef struct packed {
    logic inc;
    logic load;
    logic [15:0] value;
  } ptr_op_t;

  // decoded configuration outputs
  typedef struct packed {
    logic watchdog_config_enable;
    logic reset_pin_disable;
    logic port_reset_level;
    logic brownout_setting;
    logic clock_rate_select;
    osc_mode_t oscillator_select;
  } cfg_decode_t;
endpackage

// ==== logic/otp_store.sv ====
`timescale 1ns/1ns
module otp_store
  import sys_config_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [cust_aw-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [cust_aw-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // customer bytes; cells start blank, programming only clears bits
  logic [7:0] mem [cust_depth];
  genvar g;
  generate
    for (g = 0; g < cust_depth; g++)
    begin : cell_gen
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          mem[g] <= cfg_unprog_value;
        end
        else if (wr_en && wr_addr == cust_aw'(g))
        begin
          mem[g] <= mem[g] & wr_data;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_data <= cfg_unprog_value;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ==== logic/sys_config_aux.sv ====
`timescale 1ns/1ns
module sys_config_aux
  import sys_config_pkg::*;
#(
  parameter logic [7:0] sig_byte_0 = 8'h15, // arbitrary value
  parameter logic [7:0] sig_byte_1 = 8'h2A, // arbitrary value
  parameter logic [7:0] sig_byte_2 = 8'h3C  // arbitrary value
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on,
  input wire sfr_req_t sfr_req,
  input wire ptr_op_t ptr_op,
  input wire logic code_rd,
  input wire logic [7:0] code_offset,
  input wire logic xdata_rd,
  input wire logic [7:0] watchdog_ctrl_in,
  input wire logic prog_mode,
  input wire logic prog_clk_pin,
  input wire logic prog_data_in,
  output logic prog_data_out,
  output logic prog_data_oe,
  output logic [7:0] sfr_rdata,
  output logic [15:0] data_pointer,
  output logic [15:0] code_addr,
  output logic [7:0] code_rdata,
  output logic code_hit,
  output logic [7:0] xdata_rdata,
  output logic core_reset,
  output logic [15:0] restart_pc,
  output cfg_decode_t cfg,
  output logic reset_pin_enable,
  output logic port_reset_value,
  output logic [3:0] clocks_per_cycle,
  output logic [7:0] watchdog_ctrl
);
  logic [7:0] auxiliary_control;
  logic [15:0] ptr_bank [2];
  logic [7:0] system_config_byte_one;
  logic [7:0] system_config_byte_two;
  logic [7:0] cfg_latched;
  logic security_bit_one;
  logic security_bit_two;
  logic pointer_select;
  logic [15:0] sel_ptr;
  logic [15:0] next_code_addr;
  logic clk_s1, clk_s2, clk_s3, din_s1, din_s2, mode_s1, mode_s2;
  logic clk_rise, clk_fall;
  link_state_t link_state;
  logic [prog_frame_bits-1:0] shift;
  logic [5:0] bit_count;
  logic cust_wr;
  logic [7:0] cust_rd;
  logic [7:0] cust_rdata;
  prog_cmd_t cmd;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data;

  assign pointer_select = auxiliary_control[aux_dps_bit];
  assign sel_ptr = ptr_bank[pointer_select];
  assign cmd = prog_cmd_t'(shift[27:24]);
  assign cmd_addr = shift[23:8];
  assign cmd_data = shift[7:0];

  // ----------------------------------------------------------------
  // auxiliary control and software reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      auxiliary_control <= aux_reset_value;
      core_reset <= 1'b0;
      restart_pc <= restart_address;
    end
    else if (sfr_req.wr && sfr_req.addr == aux_ctrl_addr)
    begin
      if (sfr_req.wdata[aux_software_reset_trigger_bit])
      begin
        auxiliary_control <= aux_reset_value;
        core_reset <= 1'b1;
        restart_pc <= restart_address;
      end
      else
      begin
        auxiliary_control <= sfr_req.wdata & aux_write_mask;
        auxiliary_control[aux_software_reset_trigger_bit] <= 1'b0;
        core_reset <= 1'b0;
      end
    end
    else
    begin
      core_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // dual data pointers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : ptr_gen
      always_ff @(posedge clk)
      begin
        if (!reset_n || core_reset)
        begin
          ptr_bank[g] <= ptr_reset_value;
        end
        else if (pointer_select == 1'(g))
        begin
          if (ptr_op.load)
          begin
            ptr_bank[g] <= ptr_op.value;
          end
          else if (ptr_op.inc)
          begin
            ptr_bank[g] <= ptr_bank[g] + 16'h0001;
          end
          else if (sfr_req.wr && sfr_req.addr == ptr_low_addr)
          begin
            ptr_bank[g][7:0] <= sfr_req.wdata;
          end
          else if (sfr_req.wr && sfr_req.addr == ptr_high_addr)
          begin
            ptr_bank[g][15:8] <= sfr_req.wdata;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sfr_rdata <= 8'h00;
      data_pointer <= ptr_reset_value;
    end
    else
    begin
      data_pointer <= sel_ptr;
      case (sfr_req.addr)
        aux_ctrl_addr: sfr_rdata <= auxiliary_control;
        ptr_low_addr: sfr_rdata <= sel_ptr[7:0];
        ptr_high_addr: sfr_rdata <= sel_ptr[15:8];
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration space reads
  // ----------------------------------------------------------------
  assign next_code_addr = sel_ptr + {8'h00, code_offset};
  assign cust_rd = next_code_addr[7:0] - cust_base[7:0];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      code_addr <= 16'h0000;
      code_rdata <= 8'h00;
      code_hit <= 1'b0;
      xdata_rdata <= 8'h00;
    end
    else
    begin
      code_addr <= next_code_addr;
      code_hit <= 1'b0;
      if (code_rd)
      begin
        code_hit <= 1'b1;
        if (next_code_addr == sig_addr_0)
        begin
          code_rdata <= sig_byte_0;
        end
        else if (next_code_addr == sig_addr_1)
        begin
          code_rdata <= sig_byte_1;
        end
        else if (next_code_addr == sig_addr_2)
        begin
          code_rdata <= sig_byte_2;
        end
        else if (next_code_addr >= cust_base && next_code_addr <= cust_last)
        begin
          code_rdata <= cust_rdata;
        end
        else
        begin
          code_hit <= 1'b0;
        end
      end
      if (xdata_rd)
      begin
        if (sel_ptr == cfg1_addr)
        begin
          xdata_rdata <= system_config_byte_one;
        end
        else if (sel_ptr == cfg2_addr)
        begin
          xdata_rdata <= system_config_byte_two;
        end
        else
        begin
          xdata_rdata <= 8'h00;
        end
      end
    end
  end

  // in programming mode the address is taken one shift ahead, so the
  // registered byte is ready when the frame executes
  otp_store cust_mem (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(cust_wr),
    .wr_addr(cmd_addr[cust_aw-1:0]),
    .wr_data(cmd_data),
    .rd_addr(mode_s2 ? shift[cust_aw+6:7] : cust_rd[cust_aw-1:0]),
    .rd_data(cust_rdata)
  );

  // ----------------------------------------------------------------
  // power-up latch and decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfg_latched <= cfg_unprog_value;
      cfg <= '1;
      reset_pin_enable <= 1'b1;
      port_reset_value <= 1'b1;
      clocks_per_cycle <= 4'(machine_cycle_clocks);
    end
    else if (power_on)
    begin
      cfg_latched <= system_config_byte_one;
      cfg.watchdog_config_enable <= system_config_byte_one[cfg_watchdog_config_enable_bit];
      cfg.reset_pin_disable <= system_config_byte_one[cfg_rpd_bit];
      cfg.port_reset_level <= system_config_byte_one[cfg_port_reset_level_bit];
      cfg.brownout_setting <= system_config_byte_one[cfg_bov_bit];
      cfg.clock_rate_select <= system_config_byte_one[cfg_clock_rate_select_bit];
      case (system_config_byte_one[2:0])
        3'b111: cfg.oscillator_select <= osc_ext_clock;
        3'b011: cfg.oscillator_select <= osc_int_rc;
        3'b010: cfg.oscillator_select <= osc_low_xtal;
        3'b001: cfg.oscillator_select <= osc_med_xtal;
        3'b000: cfg.oscillator_select <= osc_high_xtal;
        default: cfg.oscillator_select <= osc_reserved;
      endcase
      reset_pin_enable <= !system_config_byte_one[cfg_rpd_bit];
      port_reset_value <= system_config_byte_one[cfg_port_reset_level_bit];
      clocks_per_cycle <= system_config_byte_one[cfg_clock_rate_select_bit] ?
        4'(machine_cycle_fast) : 4'(machine_cycle_clocks);
    end
  end

  // ----------------------------------------------------------------
  // watchdog overrides
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      watchdog_ctrl <= 8'h00;
    end
    else if (cfg_latched[cfg_watchdog_config_enable_bit])
    begin
      watchdog_ctrl <= {watchdog_ctrl_in[7:5], 1'b1, 1'b0,
        watchdog_ctrl_in[2:0]};
    end
    else
    begin
      watchdog_ctrl <= {watchdog_ctrl_in[7:5], 1'b0,
        watchdog_ctrl_in[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // serial programming link
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      {clk_s1, clk_s2, clk_s3} <= 3'b000;
      {din_s1, din_s2, mode_s1, mode_s2} <= 4'h0;
    end
    else
    begin
      clk_s1 <= prog_clk_pin;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      din_s1 <= prog_data_in;
      din_s2 <= din_s1;
      mode_s1 <= prog_mode;
      mode_s2 <= mode_s1;
    end
  end
  assign clk_rise = clk_s2 && !clk_s3;
  assign clk_fall = !clk_s2 && clk_s3;
  assign cust_wr = link_state == link_exec && cmd == cmd_write_code &&
    security_bit_one && cmd_addr >= cust_base &&
    cmd_addr <= cust_last;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      link_state <= link_idle;
      shift <= '0;
      bit_count <= 6'h00;
      prog_data_out <= 1'b0;
      prog_data_oe <= 1'b0;
      system_config_byte_one <= cfg_unprog_value;
      system_config_byte_two <= cfg_unprog_value;
      security_bit_one <= 1'b1;
      security_bit_two <= 1'b1;
    end
    else if (!mode_s2)
    begin
      link_state <= link_idle;
      prog_data_oe <= 1'b0;
      bit_count <= 6'h00;
    end
    else
    begin
      case (link_state)
        link_idle:
        begin
          prog_data_oe <= 1'b0;
          bit_count <= 6'h00;
          link_state <= link_shift_in;
        end
        link_shift_in:
        begin
          if (clk_rise)
          begin
            shift <= {shift[prog_frame_bits-2:0], din_s2};
            bit_count <= bit_count + 6'h01;
            if (bit_count == 6'(prog_frame_bits - 1))
            begin
              link_state <= link_exec;
            end
          end
        end
        link_exec:
        begin
          bit_count <= 6'h00;
          link_state <= link_shift_in;
          case (cmd)
            cmd_write_cfg:
            begin
              if (security_bit_one)
              begin
                if (cmd_addr == cfg1_addr)
                begin
                  system_config_byte_one <= system_config_byte_one & cmd_data;
                end
                else if (cmd_addr == cfg2_addr)
                begin
                  system_config_byte_two <= system_config_byte_two & cmd_data;
                end
              end
            end
            cmd_prog_sb1: security_bit_one <= 1'b0;
            cmd_prog_sb2: security_bit_two <= 1'b0;
            cmd_read_code, cmd_read_cfg:
            begin
              if (security_bit_one || security_bit_two)
              begin
                shift <= {cmd == cmd_read_cfg ?
                  (cmd_addr == cfg1_addr ? system_config_byte_one :
                   system_config_byte_two) :
                  cust_rdata,
                  24'h000000};
                link_state <= link_shift_out;
              end
            end
            default: link_state <= link_shift_in;
          endcase
        end
        link_shift_out:
        begin
          prog_data_oe <= 1'b1;
          if (clk_fall)
          begin
            prog_data_out <= shift[prog_frame_bits-1];
            shift <= {shift[prog_frame_bits-2:0], 1'b0};
            bit_count <= bit_count + 6'h01;
            if (bit_count == 6'h08)
            begin
              prog_data_oe <= 1'b0;
              bit_count <= 6'h00;
              link_state <= link_shift_in;
            end
          end
        end
        default: link_state <= link_idle;
      endcase
    end
  end
endmodule

// ==== dv/sys_config_aux_properties.sv ====
`timescale 1ns/1ns
module sys_config_aux_properties
  import sys_config_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on,
  input wire sfr_req_t sfr_req,
  input wire ptr_op_t ptr_op,
  input wire logic [7:0] sfr_rdata,
  input wire logic [15:0] data_pointer,
  input wire logic core_reset,
  input wire logic [15:0] restart_pc,
  input wire cfg_decode_t cfg,
  input wire logic reset_pin_enable,
  input wire logic port_reset_value,
  input wire logic [3:0] clocks_per_cycle,
  input wire logic [7:0] watchdog_ctrl
);
  logic software_reset_trigger_wr;
  logic quiet;
  logic powered;
  logic powered_d;
  assign software_reset_trigger_wr = sfr_req.wr && sfr_req.addr == aux_ctrl_addr
    && sfr_req.wdata[aux_software_reset_trigger_bit];
  assign quiet = !ptr_op.inc && !ptr_op.load && !sfr_req.wr;
  // outputs follow cfg only once power-up latching has happened
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      powered <= 1'b0;
      powered_d <= 1'b0;
    end
    else
    begin
      powered <= powered || power_on;
      powered_d <= powered;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ------------------------------
  // assertions
  // ------------------------------
  soft_reset_a: assert property (
    software_reset_trigger_wr |=> core_reset ##1 !core_reset)
    else $error("software reset pulse missing");
  reset_cause_a: assert property (
    core_reset |-> $past(software_reset_trigger_wr))
    else $error("reset without trigger write");
  restart_pc_a: assert property (
    core_reset |-> restart_pc == restart_address)
    else $error("restart address not zero");
  bit_two_a: assert property (
    sfr_req.rd && sfr_req.addr == aux_ctrl_addr
      |=> !sfr_rdata[aux_zero_bit])
    else $error("aux bit two read as one");
  pointer_load_a: assert property (
    ptr_op.load && !sfr_req.wr ##1 quiet [*2]
      |-> data_pointer == $past(ptr_op.value, 2))
    else $error("pointer load value lost");
  pointer_inc_a: assert property (
    quiet ##1 ptr_op.inc && !ptr_op.load && !sfr_req.wr ##1 quiet [*2]
      |-> data_pointer == $past(data_pointer, 2) + 16'h0001)
    else $error("pointer increment wrong");
  cfg_reset_a: assert property (
    $rose(reset_n) |-> cfg == 8'hFF && clocks_per_cycle == 4'hC)
    else $error("configuration not unprogrammed after reset");
  clock_rate_a: assert property (
    powered_d && $stable(cfg)
      |-> clocks_per_cycle == (cfg.clock_rate_select ? 4'h6 : 4'hC))
    else $error("machine cycle length wrong");
  reset_pin_a: assert property (
    powered_d && $stable(cfg)
      |-> reset_pin_enable == !cfg.reset_pin_disable)
    else $error("reset pin function wrong");
  port_level_a: assert property (
    powered_d && $stable(cfg) |-> port_reset_value == cfg.port_reset_level)
    else $error("port reset level wrong");
  watchdog_force_a: assert property (
    powered_d && cfg.watchdog_config_enable && $stable(cfg)
      |-> watchdog_ctrl[4] && !watchdog_ctrl[3])
    else $error("watchdog run or clock not forced");
  cover property (software_reset_trigger_wr);
  cover property (ptr_op.inc);
  cover property (powered_d && !cfg.clock_rate_select);
endmodule

bind sys_config_aux sys_config_aux_properties i_props (.clk, .reset_n,
  .power_on, .sfr_req, .ptr_op, .sfr_rdata, .data_pointer, .core_reset,
  .restart_pc, .cfg, .reset_pin_enable, .port_reset_value,
  .clocks_per_cycle, .watchdog_ctrl);

// ==== dv/prog_link_model.sv ====
`timescale 1ns/1ns
module prog_link_model
  import sys_config_pkg::*;
(
  input wire logic clk,
  input wire logic prog_data_out,
  input wire logic prog_data_oe,
  output logic prog_mode,
  output logic prog_clk_pin,
  output logic prog_data_in
);
  logic drv_en = 1'b0;
  logic drv_bit = 1'b0;
  logic sb1_sent = 1'b0;
  initial
  begin
    prog_mode = 1'b0;
    prog_clk_pin = 1'b0;
  end
  // released line rests on its pull-up
  assign prog_data_in = prog_data_oe ? prog_data_out
    : (drv_en ? drv_bit : 1'b1);
  task automatic half;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // ------------------------------
  // one frame, link clock idle low between frames
  // ------------------------------
  task automatic frame(input prog_cmd_t cmd, input logic [15:0] ad,
    input logic [7:0] wd, output logic [7:0] rd);
    logic [31:0] w;
    w = {4'h0, cmd, ad, wd};
    rd = 8'h00;
    if (cmd == cmd_prog_sb2 && !sb1_sent) return;
    sb1_sent = sb1_sent || (cmd == cmd_prog_sb1);
    prog_mode = 1'b1;
    drv_en = 1'b1;
    for (int i = 31; i >= 0; i--)
    begin
      drv_bit = w[i];
      half;
      prog_clk_pin = 1'b1;
      half;
      prog_clk_pin = 1'b0;
    end
    drv_en = 1'b0;
    if (cmd == cmd_read_code || cmd == cmd_read_cfg)
      for (int i = 0; i < 8; i++)
      begin
        half;
        prog_clk_pin = 1'b1;
        half;
        rd = {rd[6:0], prog_data_in};
        prog_clk_pin = 1'b0;
      end
    half;
    // mode drops between frames so each frame starts aligned
    prog_mode = 1'b0;
    half;
  endtask
endmodule

// ==== dv/sys_config_and_aux_control_test.sv ====
`timescale 1ns/1ns
module sys_config_and_aux_control_test;
  import sys_config_pkg::*;
  localparam logic [7:0] sg0 = 8'h15; // arbitrary value
  localparam logic [7:0] sg1 = 8'h2A; // arbitrary value
  localparam logic [7:0] sg2 = 8'h3C; // arbitrary value
  logic clk = 0, reset_n = 0, power_on = 0, code_rd = 0, xdata_rd = 0;
  sfr_req_t sfr_req = '0;
  ptr_op_t ptr_op = '0;
  logic [7:0] code_offset = '0, watchdog_ctrl_in = 8'h08;
  logic prog_mode, prog_clk_pin, prog_data_in, prog_data_out, prog_data_oe;
  logic [7:0] sfr_rdata, code_rdata, xdata_rdata, watchdog_ctrl, q, v, d, mem;
  logic [15:0] data_pointer, code_addr, restart_pc, a, b;
  logic code_hit, core_reset, reset_pin_enable, port_reset_value;
  logic [4:0] k;
  logic h;
  cfg_decode_t cfg;
  logic [3:0] clocks_per_cycle;
  int err_total = 0, checks_done = 0;
  always #4 clk = ~clk;
  sys_config_aux #(.sig_byte_0(sg0), .sig_byte_1(sg1), .sig_byte_2(sg2))
    i_dut (.*);
  prog_link_model i_prog (.*);
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sfr(logic w, logic [7:0] ad, logic [7:0] wd);
    sfr_req <= {w, ~w, ad, wd};
    @(posedge clk);
    sfr_req <= '0;
    @(negedge clk);
    q = sfr_rdata;
    // pointer and reset effects need two more edges to show
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ptr(logic i, logic l, logic [15:0] val);
    ptr_op <= {i, l, val};
    @(posedge clk);
    ptr_op <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse_rd(logic x, logic [7:0] off);
    code_offset <= off;
    @(posedge clk);
    code_rd <= ~x;
    xdata_rd <= x;
    @(posedge clk);
    code_rd <= 1'b0;
    xdata_rd <= 1'b0;
    @(negedge clk);
    h = code_hit;
    @(posedge clk);
    @(negedge clk);
    q = x ? xdata_rdata : code_rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    give_verdict;
  end
  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    void'($urandom(32'h7CE7));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("cfg", cfg, 16'h00FF);
    check("cycle clocks", clocks_per_cycle, 16'h000C);
    check("port level", port_reset_value, 16'h0001);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'hF7 : 8'($urandom()) & 8'hF7;
      sfr(1'b1, aux_ctrl_addr, v);
      sfr(1'b0, aux_ctrl_addr, 8'h00);
      check("aux", q, v & aux_write_mask);
    end
    $display("aux test done");
    a = 16'($urandom());
    b = 16'($urandom());
    sfr(1'b1, aux_ctrl_addr, 8'h00);
    ptr(1'b0, 1'b1, a);
    sfr(1'b1, aux_ctrl_addr, 8'h01);
    ptr(1'b0, 1'b1, b);
    ptr(1'b1, 1'b0, 16'h0000);
    b = b + 16'h0001;
    check("pointer one", data_pointer, b);
    sfr(1'b0, ptr_high_addr, 8'h00);
    check("high byte", q, b[15:8]);
    sfr(1'b1, ptr_low_addr, 8'hFF);
    sfr(1'b1, aux_ctrl_addr, 8'h00);
    check("pointer zero", data_pointer, a);
    sfr(1'b0, ptr_low_addr, 8'h00);
    check("low byte", q, a[7:0]);
    sfr(1'b1, aux_ctrl_addr, 8'h01);
    check("pointer one", data_pointer, {b[15:8], 8'hFF});
    sfr(1'b1, aux_ctrl_addr, 8'h09);
    check("pointer reset", data_pointer, ptr_reset_value);
    sfr(1'b0, aux_ctrl_addr, 8'h00);
    check("aux reset", q, aux_reset_value);
    $display("pointer test done");
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 2) ? sig_addr_2 : sig_addr_0;
      ptr(1'b0, 1'b1, a);
      pulse_rd(1'b0, (i == 1) ? 8'h01 : 8'h00);
      check("signature", q, (i == 0) ? sg0 : (i == 1) ? sg1 : sg2);
      check("code hit", h, 1'b1);
      check("code address", code_addr, a + ((i == 1) ? 16'h1 : 16'h0));
    end
    $display("signature test done");
    mem = cfg_unprog_value;
    for (int i = 0; i < 4; i++)
    begin
      v = {5'($urandom()), (i == 1) ? 3'b011 : (i == 2) ? 3'b010 : 3'b000};
      v[7] = v[7] && i != 3;
      if (i == 0)
        v = 8'hFF;
      else
        i_prog.frame(cmd_write_cfg, cfg1_addr, v, q);
      check("cfg held", cfg, {5'h00, mem[7:3], mem[2:0]});
      mem = mem & v;
      power_on <= 1'b1;
      @(posedge clk);
      power_on <= 1'b0;
      repeat (3) @(posedge clk);
      check("cfg", cfg, {8'h00, mem});
      check("cycle clocks", clocks_per_cycle, mem[3] ? 4'h6 : 4'hC);
      check("pin enable", reset_pin_enable, !mem[6]);
      check("port level", port_reset_value, mem[5]);
      if (mem[7])
        check("watchdog", watchdog_ctrl, 8'h10);
      else
        check("watchdog", watchdog_ctrl, 8'h08);
      ptr(1'b0, 1'b1, cfg1_addr);
      pulse_rd(1'b1, 8'h00);
      check("config read", q, mem);
      i_prog.frame(cmd_read_cfg, cfg1_addr, 8'h00, q);
      check("config verify", q, mem);
    end
    $display("config test done");
    k = 5'($urandom());
    d = 8'($urandom()) & 8'h7F;
    a = cust_base + {11'h000, k};
    i_prog.frame(cmd_write_code, a, d, q);
    ptr(1'b0, 1'b1, cust_base);
    pulse_rd(1'b0, {3'h0, k});
    check("customer byte", q, d);
    check("customer hit", h, 1'b1);
    i_prog.frame(cmd_read_code, a, 8'h00, q);
    check("verify", q, d);
    i_prog.frame(cmd_prog_sb1, 16'h0000, 8'h00, q);
    i_prog.frame(cmd_write_code, a, 8'h00, q);
    pulse_rd(1'b0, {3'h0, k});
    check("locked byte", q, d);
    i_prog.frame(cmd_read_code, a, 8'h00, q);
    check("verify locked", q, d);
    i_prog.frame(cmd_prog_sb2, 16'h0000, 8'h00, q);
    i_prog.frame(cmd_read_code, a, 8'h00, q);
    check("verify blocked", q, 8'hFF);
    $display("security test done");
    give_verdict;
  end
endmodule
